// ---- src/ulm_pkg.sv ----
package ulm_pkg;

   // ==========================================================
   // register word indexes on the avalon port
   localparam logic [2:0] OFS_LINE_CONTROL  = 3'h0;
   localparam logic [2:0] OFS_MODEM_CONTROL = 3'h1;
   localparam logic [2:0] OFS_LINE_STATUS   = 3'h2;
   localparam logic [2:0] OFS_MODEM_STATUS  = 3'h3;
   localparam logic [2:0] OFS_AUX_CONTROL   = 3'h4;

   // ==========================================================
   // line control fields
   localparam int LC_PARITY_EN  = 3;
   localparam int LC_PARITY_SEL = 4;
   localparam int LC_PARITY_FRC = 5;
   localparam int LC_BREAK      = 6;
   localparam int LC_DIVISOR    = 7;

   // ==========================================================
   // modem output control fields
   localparam int MC_DTR      = 0;
   localparam int MC_RTS      = 1;
   localparam int MC_AUX1     = 2;
   localparam int MC_AUX2     = 3;
   localparam int MC_LOOP     = 4;
   localparam int MC_XON_ANY  = 5;
   localparam int MC_IR       = 6;
   localparam int MC_PRESCALE = 7;
   localparam int MC_ENH_LO   = 5;

   // ==========================================================
   // aux control fields
   localparam int AUX_ENHANCED = 0;
   localparam int AUX_MS_IRQ   = 1;

   // ==========================================================
   // reset values and sizes
   localparam logic [7:0] LINE_CONTROL_RST  = 8'h00;
   localparam logic [7:0] MODEM_CONTROL_RST = 8'h00;
   localparam logic [1:0] AUX_CONTROL_RST   = 2'h0;
   localparam logic [5:0] PIN_IDLE          = 6'h1f;
   localparam int         NUM_PINS          = 6;
   localparam int         RX_DEPTH          = 32;
   localparam int         PTR_W             = 5;
   localparam logic [1:0] PRESCALE_LAST     = 2'h3;

   // synchronised pin indexes
   localparam int PIN_CTS  = 0;
   localparam int PIN_DSR  = 1;
   localparam int PIN_RI   = 2;
   localparam int PIN_CD   = 3;
   localparam int PIN_RX   = 4;
   localparam int PIN_IRRX = 5;

   typedef logic [7:0] ulm_byte_t;

endpackage

// ---- src/ulm_parity_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface ulm_parity_if;
   logic       enable;
   logic       even;
   logic       forced;
   logic [7:0] txData;
   logic       txBit;
   logic [7:0] rxData;
   logic       rxBit;
   logic       rxError;

   modport ctrl (output enable, even, forced, txData, rxData, rxBit,
                 input txBit, rxError);
   modport gen  (input enable, even, forced, txData, rxData, rxBit,
                 output txBit, rxError);
endinterface

`default_nettype wire

// ---- src/ulm_parity_gen.sv ----
`timescale 1ns/1ps
`default_nettype none

module ulm_parity_gen
(
   input  wire logic core_clk,
   input  wire logic reset,
   ulm_parity_if.gen par
);
   import ulm_pkg::*;

   // ==========================================================
   // parity bit selection
   function automatic logic parity_of(input ulm_byte_t d, input logic even,
                                      input logic forced);
      parity_of = forced ? ~even : (even ? ^d : ~^d);
   endfunction

   wire logic txNext;
   wire logic rxExpect;
   logic      txBit_reg;

   assign txNext      = parity_of(par.txData, par.even, par.forced);
   assign rxExpect    = parity_of(par.rxData, par.even, par.forced);
   assign par.txBit   = txBit_reg;
   assign par.rxError = par.enable & (rxExpect != par.rxBit);

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
         txBit_reg <= 1'b0;
      else
         txBit_reg <= txNext;
   end

   property p_forced_bit;
      @(posedge core_clk) disable iff (reset)
      par.forced |=> txBit_reg == !$past(par.even);
   endproperty
   a_forced_bit: assert property (p_forced_bit)
      else $error("forced parity bit wrong");

endmodule

`default_nettype wire

// ---- src/ulm_line_modem_control.sv ----
// Function
// - odd, even, forced one or zero parity
// - break bit holds transmit output low unless loopback or infrared
// - line-control bit 7 selects divisor registers
// - modem bit 0 drives terminal-ready low
// - modem bit 1 drives request-to-send low unless autoRtsEnable
// - bit 2 sets infrared receive polarity
// - loopback routes bit 2 to ring status
// - bit 3 enables interrupts, spare two low
// - bit 4 enables internal local loopback
// - xon-any resumes transmitter on any character
// - bits 5-7 writable only with enhanced enable
// - bit 6 routes data through infrared codec while enhanced, not loopback
// - bit 7 divides baud clock by four
// - status bit 0 means received data waiting
// - full fifo sets overrun, drops character
// - per-character parity and framing tags shown
// - break tag, only one break character loaded
// - status bit 5 shows transmit holding empty
// - status bit 6 shows transmitter fully idle
// - status bit 7 while any tagged character
// - change flags on clear, ready, carrier
// - ring flag on low-to-high ring input
// - upper status bits show inputs or loopback
//
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

module ulm_line_modem_control
(
   input  wire logic               core_clk,
   input  wire logic               reset,
   input  wire logic [2:0]         avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire logic [31:0]        avs_writedata,
   input  wire logic [3:0]         avs_byteenable,
   output logic      [31:0]        avs_readdata,
   output logic                    avs_waitrequest,
   input  wire logic               txSerialIn,
   output logic                    txPin,
   output logic                    irTxPin,
   input  wire logic               rxPin,
   input  wire logic               irRxPin,
   output logic                    rxSerialOut,
   input  wire logic               clearToSendIn_n,
   input  wire logic               dataSetReadyIn_n,
   input  wire logic               ringIndicatorIn_n,
   input  wire logic               carrierDetectIn_n,
   output logic                    terminalReadyOut_n,
   output logic                    requestToSendOut_n,
   output logic                    spareOutputOne_n,
   output logic                    spareOutputTwo_n,
   input  wire logic               autoRtsEnable,
   input  wire logic               autoRtsLevel_n,
   output logic                    interruptOutEnable,
   output logic                    modemStatusIrq,
   output logic                    baudClockTick,
   output logic                    divisorSelect,
   input  wire ulm_pkg::ulm_byte_t txParityData,
   output logic                    txParityBit,
   output logic                    parityEnable,
   input  wire logic               rxCharValid,
   input  wire ulm_pkg::ulm_byte_t rxCharData,
   input  wire logic               rxCharParity,
   input  wire logic               rxCharFraming,
   input  wire logic               rxCharBreak,
   input  wire logic               rxIsFlowChar,
   input  wire logic               softFlowActive,
   input  wire logic               rxPop,
   output logic                    txResume,
   input  wire logic               txHoldEmpty,
   input  wire logic               txShiftEmpty
);
   import ulm_pkg::*;

   // ==========================================================
   // bus slave: one wait cycle, read sampled and cleared on entry
   logic       ack_reg;
   logic [7:0] lineControl_reg;
   logic [7:0] modemControl_reg;
   logic [1:0] auxControl_reg;
   logic [7:0] readByte_reg;

   wire logic request    = avs_read | avs_write;
   wire logic readTake   = avs_read & ~ack_reg;
   wire logic writeTake  = avs_write & ack_reg & avs_byteenable[0];
   wire logic wrLine     = writeTake & (avs_address == OFS_LINE_CONTROL);
   wire logic wrModem    = writeTake & (avs_address == OFS_MODEM_CONTROL);
   wire logic wrAux      = writeTake & (avs_address == OFS_AUX_CONTROL);
   wire logic rdLineStat = readTake & (avs_address == OFS_LINE_STATUS);
   wire logic rdModemSt  = readTake & (avs_address == OFS_MODEM_STATUS);
   wire logic enhanced   = auxControl_reg[AUX_ENHANCED];
   wire logic loopback   = modemControl_reg[MC_LOOP];
   wire logic irActive   = modemControl_reg[MC_IR] & enhanced;

   assign avs_waitrequest = request & ~ack_reg;
   assign avs_readdata    = {24'h000000, readByte_reg};

   // ==========================================================
   // control registers
   wire logic [7:0] modemWrite = avs_writedata[7:0];
   wire logic [7:0] modemNext  = enhanced ? modemWrite :
      {modemControl_reg[7:MC_ENH_LO], modemWrite[MC_ENH_LO-1:0]};

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         ack_reg          <= 1'b0;
         lineControl_reg  <= LINE_CONTROL_RST;
         modemControl_reg <= MODEM_CONTROL_RST;
         auxControl_reg   <= AUX_CONTROL_RST;
      end
      else
      begin
         ack_reg <= request & ~ack_reg;
         if (wrLine)
            lineControl_reg <= avs_writedata[7:0];
         if (wrModem)
            modemControl_reg <= modemNext;
         if (wrAux)
            auxControl_reg <= avs_writedata[1:0];
      end
   end

   // ==========================================================
   // pin synchronisers, a change counts once ff2 and ff3 agree
   wire logic [5:0] pinRaw = {irRxPin, rxPin, carrierDetectIn_n, ringIndicatorIn_n,
                              dataSetReadyIn_n, clearToSendIn_n};
   logic [5:0] pinStable;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi++)
      begin : g_sync
         logic [2:0] chain_reg;
         always_ff @(posedge core_clk or posedge reset)
         begin
            if (reset)
            begin
               chain_reg     <= {3{PIN_IDLE[gi]}};
               pinStable[gi] <= PIN_IDLE[gi];
            end
            else
            begin
               chain_reg <= {chain_reg[1:0], pinRaw[gi]};
               if (chain_reg[1] == chain_reg[2])
                  pinStable[gi] <= chain_reg[2];
            end
         end
      end
   endgenerate

   // ==========================================================
   // serial path: break, infrared, loopback
   wire logic txLine    = txSerialIn & ~lineControl_reg[LC_BREAK];
   wire logic irDecoded = modemControl_reg[MC_AUX1] ? pinStable[PIN_IRRX]
                                                    : ~pinStable[PIN_IRRX];
   logic txPin_reg;
   logic irTxPin_reg;
   logic rxOut_reg;

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         txPin_reg   <= 1'b1;
         irTxPin_reg <= 1'b0;
         rxOut_reg   <= 1'b1;
      end
      else
      begin
         txPin_reg   <= (loopback | irActive) ? 1'b1 : txLine;
         irTxPin_reg <= irActive & ~loopback & ~txLine;
         rxOut_reg   <= loopback ? txLine :
                        irActive ? irDecoded : pinStable[PIN_RX];
      end
   end

   assign txPin       = txPin_reg;
   assign irTxPin     = irTxPin_reg;
   assign rxSerialOut = rxOut_reg;

   // ==========================================================
   // modem outputs and baud prescaler
   assign terminalReadyOut_n = ~modemControl_reg[MC_DTR];
   assign requestToSendOut_n = autoRtsEnable ? autoRtsLevel_n
                                             : ~modemControl_reg[MC_RTS];
   assign spareOutputOne_n   = ~modemControl_reg[MC_AUX1];
   assign spareOutputTwo_n   = ~modemControl_reg[MC_AUX2];
   assign interruptOutEnable = modemControl_reg[MC_AUX2];
   assign divisorSelect      = lineControl_reg[LC_DIVISOR];
   assign parityEnable       = lineControl_reg[LC_PARITY_EN];

   logic [1:0] prescale_reg;
   logic       tick_reg;
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         prescale_reg <= 2'h0;
         tick_reg     <= 1'b0;
      end
      else
      begin
         prescale_reg <= prescale_reg + 2'h1;
         tick_reg     <= ~modemControl_reg[MC_PRESCALE] |
                         (prescale_reg == PRESCALE_LAST);
      end
   end
   assign baudClockTick = tick_reg;

   // ==========================================================
   // parity generator
   ulm_parity_if par ();
   assign par.enable = lineControl_reg[LC_PARITY_EN];
   assign par.even   = lineControl_reg[LC_PARITY_SEL];
   assign par.forced = lineControl_reg[LC_PARITY_FRC];
   assign par.txData = txParityData;
   assign par.rxData = rxCharData;
   assign par.rxBit  = rxCharParity;
   assign txParityBit = par.txBit;

   ulm_parity_gen u_parity (
      .core_clk (core_clk),
      .reset    (reset),
      .par      (par)
   );

   // ==========================================================
   // receive tag queue; data itself lives in the receive fifo
   logic [2:0]       tagMem [RX_DEPTH];
   logic [PTR_W-1:0] wrPtr_reg;
   logic [PTR_W-1:0] rdPtr_reg;
   logic [PTR_W:0]   count_reg;
   logic [PTR_W:0]   errCount_reg;
   logic             overrun_reg;
   logic             breakHeld_reg;
   logic             resume_reg;

   wire logic       rxFull    = count_reg == RX_DEPTH[PTR_W:0];
   wire logic       rxAny     = count_reg != '0;
   wire logic [2:0] newTag    = {rxCharBreak, rxCharFraming, par.rxError};
   wire logic       dropFlow  = rxIsFlowChar & softFlowActive;
   wire logic       dropBreak = rxCharBreak & breakHeld_reg;
   wire logic       pushTry   = rxCharValid & ~dropFlow & ~dropBreak;
   wire logic       push      = pushTry & ~rxFull;
   wire logic       pop       = rxPop & rxAny;
   wire logic [2:0] headTag   = rxAny ? tagMem[rdPtr_reg] : 3'h0;
   wire logic       pushErr   = push & (newTag != 3'h0);
   wire logic       popErr    = pop & (headTag != 3'h0);

   always_ff @(posedge core_clk)
   begin
      if (push)
         tagMem[wrPtr_reg] <= newTag;
   end

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         wrPtr_reg     <= '0;
         rdPtr_reg     <= '0;
         count_reg     <= '0;
         errCount_reg  <= '0;
         overrun_reg   <= 1'b0;
         breakHeld_reg <= 1'b0;
         resume_reg    <= 1'b0;
      end
      else
      begin
         if (push)
            wrPtr_reg <= wrPtr_reg + 1'b1;
         if (pop)
            rdPtr_reg <= rdPtr_reg + 1'b1;
         count_reg    <= count_reg + {{PTR_W{1'b0}}, push} - {{PTR_W{1'b0}}, pop};
         errCount_reg <= errCount_reg + {{PTR_W{1'b0}}, pushErr}
                         - {{PTR_W{1'b0}}, popErr};
         // a new overrun wins over the clearing status read
         overrun_reg  <= (pushTry & rxFull) | (overrun_reg & ~rdLineStat);
         // line must go back high before another break is loaded
         breakHeld_reg <= (push & rxCharBreak) |
                          (breakHeld_reg & ~rxOut_reg);
         resume_reg   <= rxCharValid & modemControl_reg[MC_XON_ANY];
      end
   end
   assign txResume = resume_reg;

   wire logic [7:0] lineStatus = {errCount_reg != '0,
                                  txHoldEmpty & txShiftEmpty,
                                  txHoldEmpty,
                                  headTag,
                                  overrun_reg,
                                  rxAny};

   // ==========================================================
   // modem status
   wire logic [3:0] loopStat = {modemControl_reg[MC_AUX2], modemControl_reg[MC_AUX1],
                                modemControl_reg[MC_DTR], modemControl_reg[MC_RTS]};
   wire logic [3:0] pinStat  = ~pinStable[PIN_CD:PIN_CTS];
   wire logic [3:0] statNow  = loopback ? loopStat : pinStat;
   logic [3:0] statPrev_reg;
   logic [3:0] delta_reg;

   wire logic [3:0] change = {statNow[3] ^ statPrev_reg[3],
                              statPrev_reg[2] & ~statNow[2],
                              statNow[1:0] ^ statPrev_reg[1:0]};

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         statPrev_reg <= 4'h0;
         delta_reg    <= 4'h0;
      end
      else
      begin
         statPrev_reg <= statNow;
         // a change in the reading cycle survives the clear
         delta_reg    <= change | (delta_reg & {4{~rdModemSt}});
      end
   end

   assign modemStatusIrq = (delta_reg != 4'h0) & auxControl_reg[AUX_MS_IRQ];

   // ==========================================================
   // read data, registered at request entry
   wire logic [7:0] readMux =
      (avs_address == OFS_LINE_CONTROL)  ? lineControl_reg :
      (avs_address == OFS_MODEM_CONTROL) ? modemControl_reg :
      (avs_address == OFS_LINE_STATUS)   ? lineStatus :
      (avs_address == OFS_MODEM_STATUS)  ? {statNow, delta_reg} :
      (avs_address == OFS_AUX_CONTROL)   ? {6'h00, auxControl_reg} : 8'h00;

   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
         readByte_reg <= 8'h00;
      else if (readTake)
         readByte_reg <= readMux;
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   property p_wait_one;
      request && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one)
      else $error("waitrequest held more than one cycle");

   property p_break_low;
      lineControl_reg[LC_BREAK] && !loopback && !irActive |=> !txPin;
   endproperty
   a_break_low: assert property (p_break_low)
      else $error("break did not force transmit low");

   property p_rts_pin;
      !autoRtsEnable |-> requestToSendOut_n == !modemControl_reg[MC_RTS];
   endproperty
   a_rts_pin: assert property (p_rts_pin)
      else $error("request-to-send level wrong");

   property p_enh_lock;
      wrModem && !enhanced |=> modemControl_reg[7:5] == $past(modemControl_reg[7:5]);
   endproperty
   a_enh_lock: assert property (p_enh_lock)
      else $error("enhanced modem bits changed while locked");

   // a tick made under divide-by-four leaves the counter at zero, so three quiet cycles follow
   property p_prescale;
      $past(modemControl_reg[MC_PRESCALE]) && tick_reg
      |=> (!tick_reg || !$past(modemControl_reg[MC_PRESCALE]))[*3];
   endproperty
   a_prescale: assert property (p_prescale)
      else $error("prescaled tick too frequent");

   property p_overrun;
      pushTry && rxFull |=> overrun_reg && count_reg == $past(count_reg) - $past(pop);
   endproperty
   a_overrun: assert property (p_overrun)
      else $error("overrun not flagged or fifo changed");

   property p_ready;
      push && !pop |=> lineStatus[0];
   endproperty
   a_ready: assert property (p_ready)
      else $error("data ready missing after push");

   property p_ring_edge;
      statPrev_reg[2] && !statNow[2] |=> delta_reg[2];
   endproperty
   a_ring_edge: assert property (p_ring_edge)
      else $error("ring trailing edge not flagged");

   property p_ms_clear;
      rdModemSt && change == 4'h0 |=> delta_reg == 4'h0 && !modemStatusIrq;
   endproperty
   a_ms_clear: assert property (p_ms_clear)
      else $error("modem status read did not clear flags");

   property p_xon_any;
      rxCharValid && modemControl_reg[MC_XON_ANY] |=> txResume;
   endproperty
   a_xon_any: assert property (p_xon_any)
      else $error("xon-any did not resume transmitter");

   c_overrun:  cover property (pushTry && rxFull);
   c_loop_msr: cover property (loopback && rdModemSt);
   c_ir_mode:  cover property (irActive && !irTxPin ##1 irTxPin);

endmodule

`default_nettype wire

// ---- verif/ulm_modem_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// far-side modem: active-low pins, idle lines between frames
module ulm_modem_model
(
   input  wire logic [3:0] modemLevels,
   output logic            ctsLine_n,
   output logic            dsrLine_n,
   output logic            ringLine_n,
   output logic            carrierLine_n,
   output logic            rxLine,
   output logic            irRxLine
);
   assign {carrierLine_n, ringLine_n, dsrLine_n, ctsLine_n} = modemLevels;
   // no frames sent: rx holds mark, ir receive idles low
   assign rxLine   = 1'b1;
   assign irRxLine = 1'b0;
endmodule

`default_nettype wire

// ---- verif/ulm_line_modem_control_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module ulm_line_modem_control_test;
   import ulm_pkg::*;
   typedef struct {logic [7:0] lc; logic [7:0] mc; logic [7:0] ex;} ulm_row_t;
   logic        core_clk = 1'b0;
   logic        reset = 1'b1;
   logic [2:0]  adr = 3'h0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic        waitReq;
   logic        txPin, irTxPin, rxSerialOut, dtr_n, rts_n, sp1_n, sp2_n;
   logic        intEn, msIrq, tick, divSel, parBit, parEn, txResume;
   logic        ctsN, dsrN, riN, cdN, rxLine, irRxLine;
   logic [3:0]  modemLevels = 4'hf;
   logic        autoRts = 1'b0;
   logic        autoLvl_n = 1'b1;
   logic        rxValid = 1'b0;
   logic        rxFr = 1'b0;
   logic        rxPop = 1'b0;
   logic        txHoldE = 1'b1;
   logic        txShiftE = 1'b1;
   ulm_byte_t   rxData = 8'h00;
   logic        txSer = 1'b1;
   ulm_byte_t   parData = 8'h01;
   int          num_errors = 0;
   int          num_checks = 0;
   // parity data 8'h01 has one set bit
   ulm_row_t rows [6] = '{'{8'h08, 8'h00, 8'h9e}, '{8'h18, 8'h01, 8'hce},
      '{8'h28, 8'h02, 8'hd6}, '{8'h38, 8'h04, 8'h9a}, '{8'h88, 8'h08, 8'hbd},
      '{8'h48, 8'h00, 8'h1e}};

   always #12.5 core_clk = ~core_clk;

   ulm_modem_model ulm_modem_model_i (.modemLevels(modemLevels), .ctsLine_n(ctsN),
      .dsrLine_n(dsrN), .ringLine_n(riN), .carrierLine_n(cdN), .rxLine(rxLine),
      .irRxLine(irRxLine));

   ulm_line_modem_control ulm_line_modem_control_i (.core_clk(core_clk), .reset(reset),
      .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
      .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(waitReq),
      .txSerialIn(txSer), .txPin(txPin), .irTxPin(irTxPin), .rxPin(rxLine),
      .irRxPin(irRxLine), .rxSerialOut(rxSerialOut), .clearToSendIn_n(ctsN),
      .dataSetReadyIn_n(dsrN), .ringIndicatorIn_n(riN), .carrierDetectIn_n(cdN),
      .terminalReadyOut_n(dtr_n), .requestToSendOut_n(rts_n), .spareOutputOne_n(sp1_n),
      .spareOutputTwo_n(sp2_n), .autoRtsEnable(autoRts), .autoRtsLevel_n(autoLvl_n),
      .interruptOutEnable(intEn), .modemStatusIrq(msIrq), .baudClockTick(tick),
      .divisorSelect(divSel), .txParityData(parData), .txParityBit(parBit),
      .parityEnable(parEn), .rxCharValid(rxValid), .rxCharData(rxData),
      .rxCharParity(1'b0), .rxCharFraming(rxFr), .rxCharBreak(1'b0),
      .rxIsFlowChar(1'b0), .softFlowActive(1'b0), .rxPop(rxPop),
      .txResume(txResume), .txHoldEmpty(txHoldE), .txShiftEmpty(txShiftE));

   // ==========================================================
   // shared tasks
   task automatic final_report;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] ex);
      num_checks++;
      if (got !== ex)
      begin
         num_errors++;
         $display("BAD t=%0t got %h exp %h", $time, got, ex);
      end
   endtask

   // request held until waitrequest seen low at an edge
   task automatic acc(input logic w, input logic [2:0] a, input ulm_byte_t d,
                      output ulm_byte_t q);
      @(posedge core_clk);
      adr  <= a;
      wr   <= w;
      rd   <= !w;
      wdat <= {24'h0, d};
      // no local limit: only the watchdog ends a stuck wait
      do
      begin
         @(posedge core_clk);
      end
      while (waitReq !== 1'b0);
      q = rdat[7:0];
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task automatic wrr(input logic [2:0] a, input ulm_byte_t d);
      ulm_byte_t q;
      acc(1'b1, a, d, q);
   endtask

   task automatic rdc(input logic [2:0] a, input ulm_byte_t m, input ulm_byte_t e);
      ulm_byte_t q;
      acc(1'b0, a, 8'h00, q);
      chk(q & m, e);
   endtask

   task automatic wt;
      repeat (8) @(posedge core_clk);
      #1;
   endtask

   task automatic push(input ulm_byte_t d, input logic fr);
      @(posedge core_clk);
      rxValid <= 1'b1;
      rxData  <= d;
      rxFr    <= fr;
      @(posedge core_clk);
      rxValid <= 1'b0;
      #1;
   endtask

   task automatic pop;
      @(posedge core_clk);
      rxPop <= 1'b1;
      @(posedge core_clk);
      rxPop <= 1'b0;
   endtask

   task automatic ticks(input ulm_byte_t ex);
      ulm_byte_t n;
      n = 8'h00;
      repeat (40)
      begin
         @(posedge core_clk);
         #1;
         if (tick === 1'b1)
            n++;
      end
      chk(n, ex);
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      repeat (10) @(posedge core_clk);
      reset <= 1'b0;
      rdc(OFS_LINE_CONTROL, 8'hff, LINE_CONTROL_RST);
      rdc(OFS_MODEM_CONTROL, 8'hff, MODEM_CONTROL_RST);
      chk({6'h0, dtr_n, sp2_n}, 8'h03);
      $display("reset test done");
      for (int i = 0; i < 6; i++)
      begin
         wrr(OFS_LINE_CONTROL, rows[i].lc);
         wrr(OFS_MODEM_CONTROL, rows[i].mc);
         repeat (2) @(posedge core_clk);
         #1;
         chk({txPin, parBit, divSel, dtr_n, rts_n, sp1_n, sp2_n, intEn}, rows[i].ex);
         rdc(OFS_LINE_CONTROL, 8'hff, rows[i].lc);
      end
      wrr(OFS_LINE_CONTROL, 8'h00);
      autoRts   <= 1'b1;
      autoLvl_n <= 1'b0;
      parData   <= 8'h03;
      wt();
      chk({6'h0, rts_n, parBit}, 8'h01);
      @(posedge core_clk);
      autoRts <= 1'b0;
      $display("table test done");
      wrr(OFS_AUX_CONTROL, 8'h03);
      rdc(OFS_MODEM_STATUS, 8'hff, 8'h00);
      modemLevels <= 4'he;
      wt();
      chk({7'h0, msIrq}, 8'h01);
      rdc(OFS_MODEM_STATUS, 8'hff, 8'h11);
      chk({7'h0, msIrq}, 8'h00);
      rdc(OFS_MODEM_STATUS, 8'hff, 8'h10);
      modemLevels <= 4'ha;
      wt();
      rdc(OFS_MODEM_STATUS, 8'hff, 8'h50);
      modemLevels <= 4'he;
      wt();
      rdc(OFS_MODEM_STATUS, 8'hff, 8'h14);
      modemLevels <= 4'hf;
      wt();
      rdc(OFS_MODEM_STATUS, 8'hff, 8'h01);
      wrr(OFS_MODEM_CONTROL, 8'h1f);
      wt();
      rdc(OFS_MODEM_STATUS, 8'hf0, 8'hf0);
      wrr(OFS_MODEM_CONTROL, 8'h10);
      wt();
      rdc(OFS_MODEM_STATUS, 8'hf4, 8'h04);
      wrr(OFS_MODEM_CONTROL, 8'h00);
      $display("modem test done");
      txShiftE <= 1'b0;
      push(8'h41, 1'b1);
      rdc(OFS_LINE_STATUS, 8'hff, 8'ha9);
      for (int i = 0; i < 32; i++)
         push(8'h10 + 8'(i), 1'b0);
      rdc(OFS_LINE_STATUS, 8'hff, 8'hab);
      rdc(OFS_LINE_STATUS, 8'hff, 8'ha9);
      pop();
      rdc(OFS_LINE_STATUS, 8'hff, 8'h21);
      repeat (31) pop();
      txShiftE <= 1'b1;
      rdc(OFS_LINE_STATUS, 8'hff, 8'h60);
      $display("receive test done");
      wrr(OFS_MODEM_CONTROL, 8'h20);
      push(8'h55, 1'b0);
      chk({7'h0, txResume}, 8'h01);
      wrr(OFS_MODEM_CONTROL, 8'h40);
      wt();
      chk({5'h0, txPin, irTxPin, rxSerialOut}, 8'h05);
      @(posedge core_clk);
      txSer <= 1'b0;
      wt();
      chk({6'h0, txPin, irTxPin}, 8'h03);
      @(posedge core_clk);
      txSer <= 1'b1;
      wrr(OFS_MODEM_CONTROL, 8'h80);
      ticks(8'h0a);
      wrr(OFS_MODEM_CONTROL, 8'h20);
      ticks(8'h28);
      wrr(OFS_AUX_CONTROL, 8'h00);
      wrr(OFS_MODEM_CONTROL, 8'hc0);
      rdc(OFS_MODEM_CONTROL, 8'hff, 8'h20);
      rdc(3'h5, 8'hff, 8'h00);
      $display("enhanced test done");
      final_report();
   end

   // hang guard, well past the few hundred cycles the tests need
   initial
   begin
      #1000000;
      num_errors++;
      final_report();
   end
endmodule

`default_nettype wire
